//--- design/rip_pkg.sv
// Package for the serial read-pointer port: constants and carried structs
package rip_pkg;
  localparam logic [6:0] RIP_ID_CLOCK = 7'h6f; // 1101111
  localparam logic [6:0] RIP_ID_USER = 7'h57; // 1010111
  localparam logic [7:0] RIP_PTR_RESET = 8'h00;
  localparam logic [7:0] RIP_PTR_LAST = 8'h2f;
  localparam logic [7:0] RIP_PTR_WRAP = 8'h00;
  localparam logic [3:0] RIP_BIT_LAST = 4'h7;
  localparam logic [3:0] RIP_BIT_ACK = 4'h8;
  localparam logic [3:0] RIP_BIT_ZERO = 4'h0;
  localparam int RIP_SYNC_LEN = 3;

  // Sampled bus condition events
  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
    logic sda;
  } rip_bus_t;

  // Memory access request towards the register file
  typedef struct packed {
    logic rd;
    logic wr;
    logic user;
    logic [7:0] addr;
    logic [7:0] data;
  } rip_mem_t;

  typedef enum logic [2:0] {
    RIP_IDLE = 3'b000,
    RIP_ID = 3'b001,
    RIP_ADDR = 3'b011,
    RIP_WDATA = 3'b010,
    RIP_RDATA = 3'b110,
    RIP_MACK = 3'b111
  } rip_state_t;
endpackage

//--- design/rip_sync.sv
// Three-stage pin synchroniser with agreement-based change detection
`timescale 1ns/1ns
module rip_sync
  import rip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  logic [RIP_SYNC_LEN-1:0] stage;
  logic [RIP_SYNC_LEN-1:0] next_stage;
  logic level;
  logic next_level;

  // Shift chain; level moves only when stages two and three agree
  always_comb begin
    next_stage = {stage[RIP_SYNC_LEN-2:0], pin_i};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  // Registers idle high like a pulled-up bus
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= '1;
      level <= 1'b1;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  assign level_o = level;
  assign rise_o = next_level & ~level;
  assign fall_o = ~next_level & level;
endmodule // rip_sync

//--- design/rip_port.sv
// Serial slave port of a clock device: framing, pointer and read stream
// Behaviour
// - Acknowledge both ID bytes and address byte
// - Send bytes while master acknowledges each
// - Pointer loaded from address, increments per byte
// - Pointer wraps from 2Fh to 00h
// - Port ignores bus in battery-backup mode
// - Supply-monitor indication enters battery-backup mode
// - Write is ID, address, data, all acknowledged
// - Acknowledge only matching seven-bit identifiers
// - Pointer clears to 00h at power-up
// - Bytes shifted most significant bit first
`timescale 1ns/1ns
module rip_port
  import rip_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic vdd_low_i,
  output logic backup_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic mem_user_o,
  output logic [7:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i
);
  logic [1:0] rst_sync;
  logic rst_n;
  logic scl_lvl, scl_rise, scl_fall, sda_lvl, sda_rise, sda_fall;
  logic vdd_low_lvl;
  rip_bus_t bus;

  // Reset release through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rst_sync <= 2'b00;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  rip_sync u_scl (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(scl_i),
    .level_o(scl_lvl), .rise_o(scl_rise), .fall_o(scl_fall));
  rip_sync u_sda (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(sda_i),
    .level_o(sda_lvl), .rise_o(sda_rise), .fall_o(sda_fall));
  rip_sync u_vdd (.clk_i(clk_i), .rst_n_i(rst_n), .pin_i(~vdd_low_i),
    .level_o(vdd_low_lvl), .rise_o(), .fall_o());

  // Bus conditions: SDA edges while SCL high
  always_comb begin
    bus.start = sda_fall & scl_lvl & ~scl_fall;
    bus.stop = sda_rise & scl_lvl & ~scl_fall;
    bus.rise = scl_rise;
    bus.fall = scl_fall;
    bus.sda = sda_lvl;
  end

  rip_state_t state, next_state;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic [7:0] ptr, next_ptr;
  logic rw, next_rw;
  logic user, next_user;
  logic ack_drv, next_ack_drv;
  logic drive, next_drive;
  logic backup, next_backup;
  logic macked, next_macked;
  logic armed, next_armed; // Set by START: the SCL fall that follows is not a bit
  rip_mem_t mem, next_mem;

  // Identifier decode
  function automatic logic id_match(input logic [6:0] id);
    id_match = (id == RIP_ID_CLOCK) || (id == RIP_ID_USER);
  endfunction

  // Pointer advance with wrap
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = (p == RIP_PTR_LAST) ? RIP_PTR_WRAP : p + 8'h01;
  endfunction

  // Next-state logic of the framing engine
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_ptr = ptr;
    next_rw = rw;
    next_user = user;
    next_ack_drv = ack_drv;
    next_drive = drive;
    next_macked = macked;
    next_armed = armed;
    next_mem = '0;
    next_mem.addr = mem.addr;
    next_mem.data = mem.data;
    next_mem.user = mem.user;
    next_backup = ~vdd_low_lvl;
    if (backup) begin
      next_state = RIP_IDLE;
      next_drive = 1'b0;
      next_ack_drv = 1'b0;
    end else if (bus.stop) begin
      next_state = RIP_IDLE;
      next_drive = 1'b0;
      next_ack_drv = 1'b0;
    end else if (bus.start) begin
      next_state = RIP_ID;
      next_armed = 1'b1;
      next_bitcnt = RIP_BIT_ZERO;
      next_drive = 1'b0;
      next_ack_drv = 1'b0;
    end else if (state != RIP_IDLE) begin
      // Receive shifts on rise; while sending, only the master's ack is sampled
      if (bus.rise) begin
        if (state == RIP_RDATA) begin
          if (bitcnt == RIP_BIT_ACK) begin
            next_macked = ~bus.sda;
          end
        end else if (bitcnt <= RIP_BIT_LAST) begin
          next_shreg = {shreg[6:0], bus.sda};
        end
      end
      if (bus.fall && armed) begin
        next_armed = 1'b0;
      end else if (bus.fall) begin
        next_bitcnt = bitcnt + 4'h1;
        next_drive = 1'b0;
        next_ack_drv = 1'b0;
        if (bitcnt == RIP_BIT_LAST && state != RIP_RDATA) begin
          case (state)
            RIP_ID: begin
              if (id_match(shreg[7:1])) begin
                next_ack_drv = 1'b1;
                next_rw = shreg[0];
                next_user = (shreg[7:1] == RIP_ID_USER);
              end else begin
                next_state = RIP_IDLE;
              end
            end
            RIP_ADDR: begin
              next_ack_drv = 1'b1;
              next_ptr = shreg;
            end
            RIP_WDATA: begin
              next_ack_drv = 1'b1;
              next_mem.wr = 1'b1;
              next_mem.addr = ptr;
              next_mem.data = shreg;
              next_mem.user = user;
              next_ptr = ptr_inc(ptr);
            end
            default: begin
            end
          endcase
        end else if (bitcnt == RIP_BIT_ACK) begin
          next_bitcnt = RIP_BIT_ZERO;
          case (state)
            RIP_ID: begin
              if (rw) begin
                next_state = RIP_RDATA;
                next_mem.rd = 1'b1;
                next_mem.addr = ptr;
                next_mem.user = user;
              end else begin
                next_state = RIP_ADDR;
              end
            end
            RIP_ADDR: next_state = RIP_WDATA;
            RIP_WDATA: next_state = RIP_IDLE;
            RIP_RDATA: begin
              if (macked) begin
                next_mem.rd = 1'b1;
                next_mem.addr = ptr;
                next_mem.user = user;
              end else begin
                next_state = RIP_IDLE;
              end
            end
            default: next_state = RIP_IDLE;
          endcase
        end else if (bitcnt == RIP_BIT_LAST && state == RIP_RDATA) begin
          next_ptr = ptr_inc(ptr);
        end
        if (next_state == RIP_RDATA && next_bitcnt <= RIP_BIT_LAST) begin
          next_drive = 1'b1;
        end
      end
      if (mem.rd) begin
        next_shreg = mem_rdata_i;
      end else if (state == RIP_RDATA && bus.fall && bitcnt < RIP_BIT_LAST) begin
        next_shreg = {shreg[6:0], 1'b0};
      end
    end
  end

  // Framing registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= RIP_IDLE;
      bitcnt <= RIP_BIT_ZERO;
      shreg <= 8'h00;
      ptr <= RIP_PTR_RESET;
      rw <= 1'b0;
      user <= 1'b0;
      ack_drv <= 1'b0;
      drive <= 1'b0;
      backup <= 1'b0;
      macked <= 1'b0;
      armed <= 1'b0;
      mem <= '0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      ptr <= next_ptr;
      rw <= next_rw;
      user <= next_user;
      ack_drv <= next_ack_drv;
      drive <= next_drive;
      backup <= next_backup;
      macked <= next_macked;
      armed <= next_armed;
      mem <= next_mem;
    end
  end

  // Open-drain drive: ack low, data low on zero bits
  assign sda_oe_o = ack_drv | (drive & ~shreg[7]);
  assign sda_o = 1'b0;
  assign backup_o = backup;
  assign mem_rd_o = mem.rd;
  assign mem_wr_o = mem.wr;
  assign mem_user_o = mem.user;
  assign mem_addr_o = mem.addr;
  assign mem_wdata_o = mem.data;

  // Checks on the framing engine
  ptr_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.fall && state == RIP_RDATA && bitcnt == RIP_BIT_LAST && ptr == RIP_PTR_LAST
    && !backup) |=> ptr == RIP_PTR_WRAP) else $error("pointer did not wrap");
  backup_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    backup |=> !sda_oe_o && state == RIP_IDLE) else $error("bus active in backup");
  backup_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(~vdd_low_lvl) |=> backup) else $error("backup not entered");
  addr_load_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.fall && state == RIP_ADDR && bitcnt == RIP_BIT_LAST && !backup && !bus.stop)
    |=> ptr == $past(shreg) && ack_drv) else $error("address not loaded");
  id_nack_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.fall && state == RIP_ID && bitcnt == RIP_BIT_LAST && !id_match(shreg[7:1])
    && !backup && !bus.stop) |=> state == RIP_IDLE && !ack_drv)
    else $error("ack on foreign id");
  stop_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    bus.stop |=> state == RIP_IDLE && !sda_oe_o) else $error("stop not honoured");
  start_frame_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.start && !backup && !bus.stop) |=> state == RIP_ID && bitcnt == RIP_BIT_ZERO
    && ptr == $past(ptr)) else $error("restart framing wrong");
  nack_end_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.fall && state == RIP_RDATA && bitcnt == RIP_BIT_ACK && !macked && !backup
    && !bus.stop && !bus.start) |=> state == RIP_IDLE) else $error("read not ended");
  wr_ack_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (bus.fall && state == RIP_WDATA && bitcnt == RIP_BIT_LAST && !backup && !bus.stop)
    |=> mem.wr && ack_drv) else $error("write not taken");
  rd_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n) mem.rd);
  wr_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n) mem.wr);
  wrap_cov_c: cover property (@(posedge clk_i) disable iff (!rst_n)
    state == RIP_RDATA && ptr == RIP_PTR_WRAP);
endmodule // rip_port

//--- sim/rip_master.sv
// Bus master model: makes the bus clock and pulls the open-drain data line
`timescale 1ns/1ns
module rip_master (
  input wire logic clk_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  localparam int HP = 12; // Cycles per half bus period
  logic pull_low = 1'b0;
  initial scl_o = 1'b1;
  // Wired line with pull-up
  assign sda_o = ~(pull_low | sda_oe_i);
  task automatic hold(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Start or repeated start: data falls while clock high
  task automatic start_c();
    pull_low = 1'b0;
    hold(HP);
    scl_o = 1'b1;
    hold(HP);
    pull_low = 1'b1;
    hold(HP);
    scl_o = 1'b0;
    hold(HP);
  endtask
  // Stop: data rises while clock high
  task automatic stop_c();
    pull_low = 1'b1;
    hold(HP);
    scl_o = 1'b1;
    hold(HP);
    pull_low = 1'b0;
    hold(HP);
  endtask
  // One bit: set data in the low phase, sample mid high phase
  task automatic bit_c(input logic b, output logic s);
    pull_low = ~b;
    hold(HP);
    scl_o = 1'b1;
    hold(HP / 2);
    s = sda_o;
    hold(HP / 2);
    scl_o = 1'b0;
  endtask
  // Byte plus ninth bit; mack low acknowledges a received byte
  task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_c(tx[i], rx[i]);
    bit_c(mack, ack);
    pull_low = 1'b0;
  endtask
endmodule // rip_master

//--- sim/rip_port_bench.sv
// Bench for the serial read-pointer port
`timescale 1ns/1ns
module rip_port_bench;
  import rip_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vdd_low = 1'b0;
  logic scl, sda, sda_drv, sda_oe, backup, mem_rd, mem_wr, mem_user;
  logic [7:0] mem_addr, mem_wdata, rx;
  logic [7:0] mem_rdata = 8'h00;
  logic [16:0] wr_log = 17'h00000;
  logic ack;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  rip_port i_dut (.clk_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda), .sda_o(sda_drv),
    .sda_oe_o(sda_oe), .vdd_low_i(vdd_low), .backup_o(backup), .mem_rd_o(mem_rd),
    .mem_wr_o(mem_wr), .mem_user_o(mem_user), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata));
  rip_master i_m (.clk_i(clk), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  initial forever #5 clk = ~clk;
  // Memory stand-in: answer is address xor 5a, logs writes
  always @(negedge clk) begin
    if (mem_rd === 1'b1) mem_rdata = mem_addr ^ 8'h5a;
    if (mem_wr === 1'b1) wr_log = {mem_user, mem_addr, mem_wdata};
  end
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 50000) begin
      err_count++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] b, input logic exp_ack);
    i_m.xfer(b, 1'b1, rx, ack);
    check("ack", {16'h0000, ack}, {16'h0000, exp_ack});
  endtask
  task automatic recv(input logic [7:0] exp, input logic mack);
    i_m.xfer(8'hff, mack, rx, ack);
    check("data", {9'h000, rx}, {9'h000, exp});
  endtask

  // Current-address read straight after reset
  task automatic t_reset_read();
    i_m.start_c();
    send({RIP_ID_CLOCK, 1'b1}, 1'b0);
    recv(8'h00 ^ 8'h5a, 1'b1);
    check("sda out", {16'h0000, sda_drv}, 17'h00000);
    i_m.stop_c();
    $display("done reset_read");
  endtask
  // Random read across the wrap point
  task automatic t_wrap();
    i_m.start_c();
    send({RIP_ID_CLOCK, 1'b0}, 1'b0);
    send(8'h2e, 1'b0);
    i_m.start_c();
    send({RIP_ID_CLOCK, 1'b1}, 1'b0);
    recv(8'h2e ^ 8'h5a, 1'b0);
    recv(8'h2f ^ 8'h5a, 1'b0);
    recv(8'h00 ^ 8'h5a, 1'b1);
    i_m.stop_c();
    $display("done wrap");
  endtask
  // Write to user memory, then read on from the advanced pointer
  task automatic t_write();
    i_m.start_c();
    send({RIP_ID_USER, 1'b0}, 1'b0);
    send(8'h10, 1'b0);
    send(8'ha5, 1'b0);
    i_m.stop_c();
    check("write", wr_log, {1'b1, 8'h10, 8'ha5});
    i_m.start_c();
    send({RIP_ID_USER, 1'b1}, 1'b0);
    recv(8'h11 ^ 8'h5a, 1'b1);
    i_m.stop_c();
    $display("done write");
  endtask
  // Foreign identifier is refused and the rest of the frame ignored
  task automatic t_bad_id();
    i_m.start_c();
    send({7'h6e, 1'b0}, 1'b1);
    send({RIP_ID_CLOCK, 1'b0}, 1'b1);
    i_m.stop_c();
    $display("done bad_id");
  endtask
  // Supply low: backup entered and bus ignored
  task automatic t_backup();
    @(negedge clk);
    vdd_low = 1'b1;
    repeat (10) @(negedge clk);
    check("backup", {16'h0000, backup}, 17'h00001);
    i_m.start_c();
    send({RIP_ID_CLOCK, 1'b0}, 1'b1);
    i_m.stop_c();
    vdd_low = 1'b0;
    repeat (10) @(negedge clk);
    check("backup", {16'h0000, backup}, 17'h00000);
    $display("done backup");
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_reset_read();
    t_wrap();
    t_write();
    t_bad_id();
    t_backup();
    final_report();
  end
endmodule // rip_port_bench
